// ### pacs_pkg.sv
/*
  Shared constants and carrier types for the auxiliary output, slip-guard
  and status register bank of the synthesizer.
  Assumes a single synchronous clock domain and a word-wide register port.
*/
// Behaviour
// - Four-bit selector picks aux output source; 0 static
// - Selector zero drives static three-bit value out
// - Pads stay high impedance unless enable bit set
// - Per-pad disable bits turn off single drivers
// - Zero step leaves slip guard inactive
// - Nonzero step shifts detector on each 2pi wrap
// - Step MSB gives direction; needs flop release active
// - Override one: reset follows release bit, else automatic
// - Forced detector reset tristates the charge pump
// - Release bit resets one; also needs register 1 bit 15
// - Status bit 0 reports lock, reset zero
// - Status bits 3:1 report modulator overflow
// - Status bit 5 set while sweep busy
// - Temperature code is floor((T+40)/17.5)
// - Temperature code saturates at 7 and 0
package pacs_pkg;
  localparam int ADDR_W = 6;                         // Register address width
  localparam int DATA_W = 24;                        // Register data width
  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_AUX_OUTPUT_CONTROL = 6'h1B;
  localparam logic [ADDR_W-1:0] ADDR_SLIP_GUARD_CONTROL = 6'h1C;
  localparam logic [ADDR_W-1:0] ADDR_RESERVED_A         = 6'h1D;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_PROBE_CONTROL = 6'h1E;
  localparam logic [ADDR_W-1:0] ADDR_STATUS             = 6'h1F;
  localparam logic [ADDR_W-1:0] ADDR_RESERVED_B         = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_READING       = 6'h21;
  localparam logic [ADDR_W-1:0] ADDR_RESERVED_C         = 6'h22;
  // Reset and default values
  localparam logic [DATA_W-1:0] RESERVED_A_VALUE = 24'h000000;
  localparam logic [DATA_W-1:0] RESERVED_B_VALUE = 24'h000020;
  localparam logic [DATA_W-1:0] RESERVED_C_VALUE = 24'h000000;
  localparam logic [6:0]        TEMP_RESET_CODE  = 7'h1F;
  localparam logic [3:0]        SEL_STATIC       = 4'h0;
  // Field positions, aux output control
  localparam int SEL_LSB = 0;
  localparam int STATIC_LSB = 4;
  localparam int PAD_EN_BIT = 7;
  localparam int PAD_DIS_LSB = 8;
  // Field positions, slip guard control
  localparam int STEP_LSB = 0;
  localparam int OVERRIDE_BIT = 4;
  localparam int RELEASE_BIT = 5;
  // Field positions, status
  localparam int LOCK_BIT = 0;
  localparam int OVF_LSB = 1;
  localparam int SWEEP_BIT = 5;
  localparam int PROBE_EN_BIT = 0;
  // Temperature conversion, in half-degree units
  localparam int TEMP_OFFSET_HALF = 80;              // 40 C
  localparam int TEMP_STEP_HALF   = 35;              // 17.5 C
  localparam int TEMP_HI_HALF     = 165;             // 82.5 C
  localparam int TEMP_LO_HALF     = -45;             // -22.5 C
  localparam logic [6:0] TEMP_CODE_MAX = 7'h07;
  localparam logic [6:0] TEMP_CODE_MIN = 7'h00;

  // Commands toward the phase detector
  typedef struct packed {
    logic       shift;                               // One-cycle shift request
    logic       advance;                             // 1 advance, 0 retard
    logic [2:0] cycles;                              // Oscillator cycles to shift
    logic       flop_reset_n;                        // Detector flop reset, low active
    logic       pump_tristate;                       // Charge pump high impedance
  } pacs_detector_t;

  // Status inputs from the analog core
  typedef struct packed {
    logic       locked;
    logic [2:0] overflow;
    logic       sweep_busy;
  } pacs_status_t;
endpackage

// ### pacs_temp_code.sv
/*
  Temperature code converter with capture register.
  Assumes the probe sample arrives as signed half-degree units and that the
  measurement request is a one-cycle pulse in the same clock domain.
*/
`timescale 1ns/10ps
module pacs_temp_code
  import pacs_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RESET,
  input  wire logic              capture,        // Take a new sample
  input  wire logic signed [9:0] temp_half,      // Temperature, 0.5 C units
  output logic             [6:0] code            // Registered code
);

  // Floor division with both saturation ends
  function automatic logic [6:0] to_code(input logic signed [9:0] t);
    int shifted;
    shifted = int'(t) + TEMP_OFFSET_HALF;
    if (int'(t) >= TEMP_HI_HALF)
      to_code = TEMP_CODE_MAX;
    else if (int'(t) <= TEMP_LO_HALF)
      to_code = TEMP_CODE_MIN;
    else
      to_code = 7'(shifted / TEMP_STEP_HALF);
  endfunction

  // Capture register; holds the last reading between requests
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      code <= TEMP_RESET_CODE;
    else if (capture)
      code <= to_code(temp_half);
  end

  property p_temp_capture;
    @(posedge CLOCK) disable iff (RESET)
      capture |=> code == to_code($past(temp_half));
  endproperty
  a_temp_capture: assert property (p_temp_capture)
    else $error("temperature code wrong after capture");

  property p_temp_range;
    @(posedge CLOCK) disable iff (RESET)
      capture |=> code <= TEMP_CODE_MAX;
  endproperty
  a_temp_range: assert property (p_temp_range)
    else $error("temperature code above saturation");
endmodule

// ### pacs_regs.sv
/*
  Register bank for aux outputs, slip guard, probe control and status.
  Assumes the serial port front end delivers decoded single-cycle read and
  write strobes with address and data; all signals share CLOCK.
*/
`timescale 1ns/10ps
module pacs_regs
  import pacs_pkg::*;
#(
  parameter int PADS = 3                            // Aux output pad count
)
(
  input  wire logic              CLOCK,
  input  wire logic              RESET,
  input  wire logic              REG_WRITE,        // Write strobe
  input  wire logic              REG_READ,         // Read strobe
  input  wire logic [ADDR_W-1:0] REG_ADDR,         // Register address
  input  wire logic [DATA_W-1:0] REG_WDATA,        // Write data
  output logic      [DATA_W-1:0] REG_RDATA,        // Read data, registered
  output logic                   REG_RVALID,       // Read data valid pulse
  input  wire logic [15*PADS-1:0] GPO_SOURCES,     // Sources for codes 1..15
  output logic      [PADS-1:0]   GPO_OUT,          // Pad data
  output logic      [PADS-1:0]   GPO_OE_N,         // Pad enable, low drives
  input  wire logic              PHASE_WRAP,       // Detector error hit 2pi
  input  wire logic              REG1_BIT15,       // Companion enable bit
  output pacs_detector_t         DETECTOR,         // Detector commands
  input  pacs_status_t           STATUS,           // Analog status inputs
  input  wire logic              PROBE_TRIGGER,    // Probe trigger pulse
  input  wire logic signed [9:0] PROBE_TEMP,       // Probe sample
  output logic                   PROBE_ENABLE      // Probe power enable
);

  logic [10:0] aux_ctrl;                           // Aux output control bits
  logic [5:0]  slip_ctrl;                          // Slip guard control bits
  logic        probe_en;                           // Probe enable bit
  logic [6:0]  temp_code;                          // Latest temperature code
  logic [3:0]  sel;                                // Output source selector
  logic [2:0]  step;                               // Shift magnitude
  logic        guard_active;                       // Slip guard armed
  logic        next_reset_n;                       // Next detector reset level

  // Decode shared by the write processes
  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = REG_WRITE && (REG_ADDR == a);
  endfunction

  // Aux output control register; only low eleven bits are implemented
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      aux_ctrl <= '0;
    else if (hit(ADDR_AUX_OUTPUT_CONTROL))
      aux_ctrl <= REG_WDATA[10:0];
  end

  // Slip guard control; release bit comes up set
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      slip_ctrl <= '0;
      slip_ctrl[RELEASE_BIT] <= 1'b1;
    end
    else if (hit(ADDR_SLIP_GUARD_CONTROL))
      slip_ctrl <= REG_WDATA[5:0];
  end

  // Probe enable register
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      probe_en <= 1'b0;
    else if (hit(ADDR_TEMP_PROBE_CONTROL))
      probe_en <= REG_WDATA[PROBE_EN_BIT];
  end

  assign PROBE_ENABLE = probe_en;

  // Measurement only when the probe is powered; host supplies the trigger
  pacs_temp_code u_temp
  (
    .CLOCK     (CLOCK),
    .RESET     (RESET),
    .capture   (PROBE_TRIGGER && probe_en),
    .temp_half (PROBE_TEMP),
    .code      (temp_code)
  );

  assign sel = aux_ctrl[SEL_LSB +: 4];

  // Output mux and pad enables, registered so pads never glitch on decode
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      GPO_OUT  <= '0;
      GPO_OE_N <= '1;
    end
    else
    begin
      if (sel == SEL_STATIC)
        GPO_OUT <= aux_ctrl[STATIC_LSB +: PADS];
      else
        GPO_OUT <= GPO_SOURCES[(int'(sel) - 1) * PADS +: PADS];
      // Master enable gates every pad enable; per-pad bits veto single pads
      GPO_OE_N <= ~({PADS{aux_ctrl[PAD_EN_BIT]}}
                    & ~aux_ctrl[PAD_DIS_LSB +: PADS]);
    end
  end

  assign step = slip_ctrl[STEP_LSB +: 3];
  // Needs nonzero step, release bit and the companion bit together
  assign guard_active = (slip_ctrl[STEP_LSB +: 4] != 4'h0)
                        && slip_ctrl[RELEASE_BIT] && REG1_BIT15;

  // Detector flop reset source; automatic mode keeps flops released
  always_comb
  begin
    if (slip_ctrl[OVERRIDE_BIT])
      next_reset_n = slip_ctrl[RELEASE_BIT];
    else
      next_reset_n = 1'b1;
  end

  // Detector commands; a shift is issued once per wrap event
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      DETECTOR <= '0;
      DETECTOR.flop_reset_n <= 1'b1;
    end
    else
    begin
      DETECTOR.shift         <= guard_active && PHASE_WRAP;
      DETECTOR.advance       <= slip_ctrl[STEP_LSB + 3];
      DETECTOR.cycles        <= step;
      DETECTOR.flop_reset_n  <= next_reset_n;
      DETECTOR.pump_tristate <= ~next_reset_n;
    end
  end

  // Read port; reserved words return fixed values, unmapped reads zero
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      REG_RDATA  <= '0;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_READ;
      if (REG_READ)
      begin
        unique case (REG_ADDR)
          ADDR_AUX_OUTPUT_CONTROL: REG_RDATA <= {13'h0000, aux_ctrl};
          ADDR_SLIP_GUARD_CONTROL: REG_RDATA <= {18'h00000, slip_ctrl};
          ADDR_RESERVED_A:         REG_RDATA <= RESERVED_A_VALUE;
          ADDR_TEMP_PROBE_CONTROL: REG_RDATA <= {23'h000000, probe_en};
          ADDR_STATUS:             REG_RDATA <= {18'h00000, STATUS.sweep_busy,
                                                 1'b0, STATUS.overflow,
                                                 STATUS.locked};
          ADDR_RESERVED_B:         REG_RDATA <= RESERVED_B_VALUE;
          ADDR_TEMP_READING:       REG_RDATA <= {17'h00000, temp_code};
          ADDR_RESERVED_C:         REG_RDATA <= RESERVED_C_VALUE;
          default:                 REG_RDATA <= '0;
        endcase
      end
    end
  end

  // Named sequence for the static-value write-then-effect check
  sequence s_static_write;
    REG_WRITE && REG_ADDR == ADDR_AUX_OUTPUT_CONTROL
      && REG_WDATA[SEL_LSB +: 4] == SEL_STATIC;
  endsequence

  property p_static_out;
    @(posedge CLOCK) disable iff (RESET)
      s_static_write ##1 (REG_WRITE == 1'b0) [*1]
        |=> GPO_OUT == $past(REG_WDATA[STATIC_LSB +: PADS], 2);
  endproperty
  a_static_out: assert property (p_static_out)
    else $error("static value not driven on aux outputs");

  property p_pads_off;
    @(posedge CLOCK) disable iff (RESET)
      !aux_ctrl[PAD_EN_BIT] |=> GPO_OE_N == '1;
  endproperty
  a_pads_off: assert property (p_pads_off)
    else $error("pad driven while enable bit clear");

  property p_pad_disable;
    @(posedge CLOCK) disable iff (RESET)
      aux_ctrl[PAD_EN_BIT] |=> GPO_OE_N == $past(aux_ctrl[PAD_DIS_LSB +: PADS]);
  endproperty
  a_pad_disable: assert property (p_pad_disable)
    else $error("per-pad disable not applied");

  property p_no_shift_zero;
    @(posedge CLOCK) disable iff (RESET)
      slip_ctrl[STEP_LSB +: 4] == 4'h0 |=> !DETECTOR.shift;
  endproperty
  a_no_shift_zero: assert property (p_no_shift_zero)
    else $error("shift issued with zero step");

  property p_shift_on_wrap;
    @(posedge CLOCK) disable iff (RESET)
      PHASE_WRAP && guard_active |=> DETECTOR.shift
        && DETECTOR.cycles == $past(step)
        && DETECTOR.advance == $past(slip_ctrl[STEP_LSB + 3]);
  endproperty
  a_shift_on_wrap: assert property (p_shift_on_wrap)
    else $error("wrap did not produce correct shift");

  property p_release_needed;
    @(posedge CLOCK) disable iff (RESET)
      !slip_ctrl[RELEASE_BIT] || !REG1_BIT15 |=> !DETECTOR.shift;
  endproperty
  a_release_needed: assert property (p_release_needed)
    else $error("shift without release and companion bit");

  property p_forced_reset;
    @(posedge CLOCK) disable iff (RESET)
      slip_ctrl[OVERRIDE_BIT] |=> DETECTOR.flop_reset_n == $past(slip_ctrl[RELEASE_BIT]);
  endproperty
  a_forced_reset: assert property (p_forced_reset)
    else $error("override does not follow release bit");

  property p_pump_tristate;
    @(posedge CLOCK) disable iff (RESET)
      DETECTOR.pump_tristate == !DETECTOR.flop_reset_n;
  endproperty
  a_pump_tristate: assert property (p_pump_tristate)
    else $error("charge pump not tristated in reset");

  property p_status_read;
    @(posedge CLOCK) disable iff (RESET)
      REG_READ && REG_ADDR == ADDR_STATUS |=> REG_RVALID
        && REG_RDATA[LOCK_BIT] == $past(STATUS.locked)
        && REG_RDATA[OVF_LSB +: 3] == $past(STATUS.overflow)
        && REG_RDATA[SWEEP_BIT] == $past(STATUS.sweep_busy);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read mismatch");

  property p_reserved_b;
    @(posedge CLOCK) disable iff (RESET)
      REG_READ && REG_ADDR == ADDR_RESERVED_B |=> REG_RDATA == RESERVED_B_VALUE;
  endproperty
  a_reserved_b: assert property (p_reserved_b)
    else $error("reserved word read wrong value");

  // Reserved words at either side of the readable status; writes never land
  property p_reserved_a;
    @(posedge CLOCK) disable iff (RESET)
      REG_READ && REG_ADDR == ADDR_RESERVED_A |=> REG_RDATA == RESERVED_A_VALUE;
  endproperty
  a_reserved_a: assert property (p_reserved_a)
    else $error("reserved word A read wrong value");

  property p_reserved_c;
    @(posedge CLOCK) disable iff (RESET)
      REG_READ && REG_ADDR == ADDR_RESERVED_C |=> REG_RDATA == RESERVED_C_VALUE;
  endproperty
  a_reserved_c: assert property (p_reserved_c)
    else $error("reserved word C read wrong value");

  // Any nonzero selector routes its three-bit source slice onto the pads
  property p_source_select;
    @(posedge CLOCK) disable iff (RESET)
      sel != SEL_STATIC
        |=> GPO_OUT == $past(GPO_SOURCES[(int'(sel) - 1) * PADS +: PADS]);
  endproperty
  a_source_select: assert property (p_source_select)
    else $error("selected source not driven on aux outputs");

  // With the override clear the flops stay released and the pump drives
  property p_auto_release;
    @(posedge CLOCK) disable iff (RESET)
      !slip_ctrl[OVERRIDE_BIT] |=> DETECTOR.flop_reset_n && !DETECTOR.pump_tristate;
  endproperty
  a_auto_release: assert property (p_auto_release)
    else $error("detector reset not released in automatic mode");

  // Direction follows the step MSB: clear means retard
  property p_retard_dir;
    @(posedge CLOCK) disable iff (RESET)
      PHASE_WRAP && guard_active && !slip_ctrl[STEP_LSB + 3] |=> !DETECTOR.advance;
  endproperty
  a_retard_dir: assert property (p_retard_dir)
    else $error("shift direction not taken from step MSB");

  // Status read: overflow flags and the sweep flag, with the gap bit at zero
  sequence s_status_read;
    REG_READ && REG_ADDR == ADDR_STATUS;
  endsequence

  property p_overflow_read;
    @(posedge CLOCK) disable iff (RESET)
      s_status_read |=> REG_RDATA[OVF_LSB +: 3] == $past(STATUS.overflow);
  endproperty
  a_overflow_read: assert property (p_overflow_read)
    else $error("modulator overflow flags read wrong");

  property p_sweep_read;
    @(posedge CLOCK) disable iff (RESET)
      s_status_read |=> REG_RDATA[SWEEP_BIT] == $past(STATUS.sweep_busy)
        && REG_RDATA[SWEEP_BIT - 1] == 1'b0;
  endproperty
  a_sweep_read: assert property (p_sweep_read)
    else $error("sweep busy flag read wrong");

  // The reading register shows the capture register as it stood at the read
  property p_temp_read;
    @(posedge CLOCK) disable iff (RESET)
      REG_READ && REG_ADDR == ADDR_TEMP_READING
        |=> REG_RDATA[6:0] == $past(temp_code) && REG_RDATA[DATA_W-1:7] == '0;
  endproperty
  a_temp_read: assert property (p_temp_read)
    else $error("temperature reading not returned");

  // A trigger while the probe is off must leave the last reading alone
  property p_probe_gate;
    @(posedge CLOCK) disable iff (RESET)
      PROBE_TRIGGER && !probe_en |=> $stable(temp_code);
  endproperty
  a_probe_gate: assert property (p_probe_gate)
    else $error("reading changed with the probe disabled");

  // Read valid is a one-cycle echo of the strobe; data stand until next read
  property p_rvalid_pulse;
    @(posedge CLOCK) disable iff (RESET)
      !REG_READ |=> !REG_RVALID;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse)
    else $error("read valid without a read strobe");

  property p_rdata_hold;
    @(posedge CLOCK) disable iff (RESET)
      !REG_READ |=> $stable(REG_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  // Writes land in one cycle; the release bit reads back as written
  property p_slip_write;
    @(posedge CLOCK) disable iff (RESET)
      REG_WRITE && REG_ADDR == ADDR_SLIP_GUARD_CONTROL
        |=> slip_ctrl == $past(REG_WDATA[5:0]);
  endproperty
  a_slip_write: assert property (p_slip_write)
    else $error("slip guard control write lost");
endmodule

// ### pacs_host.sv
/*
  Host controller model: issues register accesses and probe triggers.
  Assumes one clock; every request starts just after a rising edge.
*/
`timescale 1ns/10ps
module pacs_host
  import pacs_pkg::*;
(
  input  wire logic              CLOCK,
  output logic                   REG_WRITE,
  output logic                   REG_READ,
  output logic      [ADDR_W-1:0] REG_ADDR,
  output logic      [DATA_W-1:0] REG_WDATA,
  output logic                   PROBE_TRIGGER
);
  // Quiet bus at time zero
  initial
  begin
    REG_WRITE = 1'b0;
    REG_READ = 1'b0;
    REG_ADDR = 6'h00;
    REG_WDATA = 24'h000000;
    PROBE_TRIGGER = 1'b0;
  end

  // One access; an idle cycle in front keeps strobes from toggling twice in a step
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge CLOCK);
    #1;
    REG_WRITE = w;
    REG_READ = ~w;
    REG_ADDR = a;
    REG_WDATA = d;
    @(posedge CLOCK);
    #1;
    REG_WRITE = 1'b0;
    REG_READ = 1'b0;
    // Released bus shows the inverse, so a stale value cannot pass
    REG_ADDR = ~a;
    REG_WDATA = ~d;
  endtask

  // Probe measurement: the trigger is pulsed for one cycle
  task automatic measure();
    @(posedge CLOCK);
    #1;
    PROBE_TRIGGER = 1'b1;
    @(posedge CLOCK);
    #1;
    PROBE_TRIGGER = 1'b0;
  endtask
endmodule

// ### testbench.sv
/*
  Self-checking bench for the register bank: reads are scored from a queue.
  Assumes the host model in pacs_host.sv drives the register port.
*/
`timescale 1ns/10ps
module testbench
  import pacs_pkg::*;
;
  logic              CLOCK = 1'b0;                  // 100 MHz clock
  logic              RESET;                         // Sync reset
  logic              REG_WRITE;
  logic              REG_READ;
  logic [ADDR_W-1:0] REG_ADDR;
  logic [DATA_W-1:0] REG_WDATA;
  logic [DATA_W-1:0] REG_RDATA;
  logic              REG_RVALID;
  logic [44:0]       GPO_SOURCES;
  logic [2:0]        GPO_OUT;
  logic [2:0]        GPO_OE_N;
  logic              PHASE_WRAP;
  logic              REG1_BIT15;
  pacs_detector_t    DETECTOR;
  pacs_status_t      STATUS;
  logic              PROBE_TRIGGER;
  logic signed [9:0] PROBE_TEMP;
  logic              PROBE_ENABLE;
  int                failures = 0;                  // Mismatch count
  int                checks_done = 0;               // Comparison count
  logic [DATA_W-1:0] expq[$];                       // Expected read data
  logic [31:0]       seed = 32'h1ABE;               // Fixed seed
  logic [31:0]       s;
  logic [3:0]        st;
  int                k;
  logic [ADDR_W-1:0] ra [8] = '{6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h3F};
  logic [DATA_W-1:0] rv [8] = '{24'h000020, 24'h000000, 24'h000000, 24'h000000,
                                24'h000020, 24'h00001F, 24'h000000, 24'h000000};
  logic [3:0]        steps [4] = '{4'h1, 4'hB, 4'h7, 4'hF};
  int                tt [7] = '{-60, -45, -44, 0, 50, 164, 165};

  always #5 CLOCK = ~CLOCK;

  pacs_host u_host (.CLOCK(CLOCK), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .PROBE_TRIGGER(PROBE_TRIGGER));

  pacs_regs #(.PADS(3)) u_dut (.CLOCK(CLOCK), .RESET(RESET), .REG_WRITE(REG_WRITE),
    .REG_READ(REG_READ), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .GPO_SOURCES(GPO_SOURCES),
    .GPO_OUT(GPO_OUT), .GPO_OE_N(GPO_OE_N), .PHASE_WRAP(PHASE_WRAP),
    .REG1_BIT15(REG1_BIT15), .DETECTOR(DETECTOR), .STATUS(STATUS),
    .PROBE_TRIGGER(PROBE_TRIGGER), .PROBE_TEMP(PROBE_TEMP), .PROBE_ENABLE(PROBE_ENABLE));

  // Xorshift generator
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected code in half-degree units; clamps win over the formula
  function automatic logic [6:0] tcode(input int t);
    if (t >= 165)
      return 7'h07;
    if (t <= -45)
      return 7'h00;
    return 7'((t + 80) / 35);
  endfunction

  task automatic check(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    expq.push_back(e);
    u_host.access(1'b0, a, 24'h000000);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    u_host.access(1'b1, a, d);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  // Pulse a 2pi wrap and look at the shift request one cycle later
  task automatic wrap(input logic sh);
    PHASE_WRAP = 1'b1;
    wait_n(1);
    PHASE_WRAP = 1'b0;
    if (sh)
      check("detector", 24'({1'b1, st, 2'b10}), 24'(DETECTOR));
    else
      check("shift", 24'h000000, 24'(DETECTOR.shift));
  endtask

  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Read scoreboard: each valid pulse takes the oldest note
  always @(posedge CLOCK)
    if (REG_RVALID === 1'b1)
    begin
      if (expq.size() > 0)
        check("REG_RDATA", expq.pop_front(), REG_RDATA);
      else
        check("REG_RVALID", 24'h000000, 24'h000001);
    end

  // Watchdog, far beyond the two hundred or so cycles the run needs
  initial
  begin
    #20000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    RESET = 1'b1;
    PHASE_WRAP = 1'b0;
    REG1_BIT15 = 1'b0;
    STATUS = '0;
    PROBE_TEMP = 10'sh000;
    GPO_SOURCES = '0;
    repeat (12) @(posedge CLOCK);
    #1;
    RESET = 1'b0;
    check("GPO_OE_N", 24'h000007, 24'(GPO_OE_N));
    // Defaults, then writes to read-only places must not stick
    for (int i = 0; i < 8; i++)
      rd(ra[i], rv[i]);
    for (int i = 1; i < 8; i++)
      if (i != 2)
        wr(ra[i], 24'(rnd()));
    for (int i = 0; i < 8; i++)
      rd(ra[i], rv[i]);
    // Static value, pad enable and per-pad disables, then alternate sources
    repeat (8)
    begin
      s = rnd();
      GPO_SOURCES = 45'({rnd(), rnd()});
      wr(6'h1B, {13'h0000, s[5:3], s[6], s[2:0], 4'h0});
      wait_n(1);
      check("GPO_OUT", 24'(s[2:0]), 24'(GPO_OUT));
      check("GPO_OE_N", 24'(s[6] ? s[5:3] : 3'b111), 24'(GPO_OE_N));
      k = (s[11:8] == 4'h0) ? 1 : int'(s[11:8]);
      wr(6'h1B, {13'h0000, s[5:3], s[6], 3'b000, 4'(k)});
      wait_n(1);
      check("GPO_OUT", 24'(GPO_SOURCES[(k-1)*3 +: 3]), 24'(GPO_OUT));
    end
    // Slip guard arming and shift commands
    REG1_BIT15 = 1'b1;
    wr(6'h1C, 24'h000020);
    wrap(1'b0);
    for (int i = 0; i < 4; i++)
    begin
      st = steps[i];
      wr(6'h1C, {18'h00000, 2'b10, st});
      wrap(1'b1);
    end
    wr(6'h1C, 24'h000005);
    wrap(1'b0);
    wr(6'h1C, 24'h000025);
    REG1_BIT15 = 1'b0;
    wrap(1'b0);
    // Forced detector reset follows the release bit and tristates the pump
    wr(6'h1C, 24'h000010);
    wait_n(1);
    check("flop_pump", 24'h000001, 24'({DETECTOR.flop_reset_n, DETECTOR.pump_tristate}));
    wr(6'h1C, 24'h000030);
    wait_n(1);
    check("flop_pump", 24'h000002, 24'({DETECTOR.flop_reset_n, DETECTOR.pump_tristate}));
    // Live status flags
    repeat (4)
    begin
      s = rnd();
      STATUS = s[4:0];
      rd(6'h1F, {18'h00000, s[0], 1'b0, s[3:1], s[4]});
    end
    // Trigger with the probe off is ignored
    PROBE_TEMP = 10'sd50;
    u_host.measure();
    rd(6'h21, 24'h00001F);
    wr(6'h1E, 24'h000001);
    check("PROBE_ENABLE", 24'h000001, 24'(PROBE_ENABLE));
    rd(6'h1E, 24'h000001);
    for (int i = 0; i < 7; i++)
    begin
      PROBE_TEMP = 10'(tt[i]);
      u_host.measure();
      rd(6'h21, 24'(tcode(tt[i])));
    end
    wait_n(4);
    check("pending_reads", 24'h000000, 24'(expq.size()));
    // Reset in mid-run brings every written register back to its default
    RESET = 1'b1;
    wait_n(2);
    RESET = 1'b0;
    check("GPO_OE_N", 24'h000007, 24'(GPO_OE_N));
    check("detector", 24'h000002, 24'(DETECTOR));
    rd(6'h1B, 24'h000000);
    rd(6'h1C, 24'h000020);
    rd(6'h1E, 24'h000000);
    rd(6'h21, 24'h00001F);
    wait_n(4);
    // A read whose valid pulse never came would otherwise vanish unscored
    check("pending_reads", 24'h000000, 24'(expq.size()));
    report_and_stop();
  end
endmodule
